/* common/tpmc_pkg.sv */
// constants for the timer counter control block: register offsets, fields, resets
// assumes an apb slave with 32-bit data, one aligned word per register
//
// Contract
// [RULE_01] up mode: overflow flag sets when counter wraps to zero past modulo
// [RULE_02] center mode: flag sets when counter steps down from modulo value
// [RULE_03] flag clears only by status read while set, then writing zero
// [RULE_04] overflow between read and write restarts clearing; flag stays set
// [RULE_05] writing one to flag leaves it; reset clears flag
// [RULE_06] interrupt request while flag and enable both set; reset clears enable
// [RULE_07] center select zero counts up, one counts up/down, all channels center
// [RULE_08] clock field: none, bus, fixed system, external pin to prescaler
// [RULE_09] external and fixed clocks synchronised to bus clock first
// [RULE_10] software sets shared channel edge select to zero with external clock
// [RULE_11] prescaler divides by two to the power of the field
// [RULE_12] prescaler follows clock selection and synchronisation
// [RULE_13] reading either counter byte latches both until the other is read
// [RULE_14] coherency restarts on reset, counter write, status write
// [RULE_15] reset clears counter and whole status/control register
// [RULE_16] debug mode freezes counter and coherency buffer state
// [RULE_17] any write to either counter byte clears the counter
// [RULE_18] up mode wraps to zero after modulo; center mode turns down
// [RULE_19] modulo all zeros or all ones gives free running counter
// [RULE_20] counter steps once per prescaler tick; stops with no clock
package tpmc_pkg;
    localparam logic [11:0] TPMC_OFF_STATUS   = 12'h000;
    localparam logic [11:0] TPMC_OFF_CNT_HIGH = 12'h004;
    localparam logic [11:0] TPMC_OFF_CNT_LOW  = 12'h008;
    localparam logic [11:0] TPMC_OFF_MODULO   = 12'h00C;
    localparam int TPMC_BIT_FLAG   = 7;
    localparam int TPMC_BIT_IRQEN  = 6;
    localparam int TPMC_BIT_CENTER = 5;
    localparam int TPMC_BIT_CLKHI  = 4;
    localparam int TPMC_BIT_PSHI   = 2;
    localparam logic [7:0]  TPMC_STATUS_RESET = 8'h00;
    localparam logic [15:0] TPMC_COUNT_RESET  = 16'h0000;
    localparam logic [15:0] TPMC_MOD_RESET    = 16'h0000;
    localparam logic [15:0] TPMC_ALL_ONES     = 16'hFFFF;
    localparam logic [6:0]  TPMC_PRE_RESET    = 7'h00;
    typedef enum logic [1:0] {
        TPMC_CLK_NONE  = 2'b00,
        TPMC_CLK_BUS   = 2'b01,
        TPMC_CLK_FIXED = 2'b10,
        TPMC_CLK_EXT   = 2'b11
    } tpmc_clk_type;
    typedef enum logic [1:0] {
        TPMC_COH_IDLE = 2'b00,
        TPMC_COH_HIGH = 2'b01,  // high byte read, low pending
        TPMC_COH_LOW  = 2'b10   // low byte read, high pending
    } tpmc_coh_type;
endpackage

/* rtl/tpmc_top.sv */
// timer counter control: status/control register, prescaler, 16-bit counter
// assumes apb master on sys_clk_i; fixed and pin clocks are asynchronous levels
//
// Added by the designer: the address map and the APB interface to the registers.
`timescale 1ns/100ps
module tpmc_top
    import tpmc_pkg::*;
(
    input  wire logic        sys_clk_i,
    input  wire logic        sys_rst_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [11:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    input  wire logic        fixed_system_clock_i,
    input  wire logic        external_pin_clock_i,
    input  wire logic        debug_mode_i,
    output logic             overflow_irq_o,
    output logic             center_aligned_o,
    output logic      [15:0] count_o
);
    // register state
    logic        overflow_flag;
    logic        overflow_irq_enable;
    logic        center_aligned_select;
    logic [1:0]  clock_select;
    logic [2:0]  prescale_field;
    logic        flag_armed;
    logic [15:0] modulo;
    logic [15:0] count;
    logic        count_down;
    logic [6:0]  prescale_cnt;
    logic [15:0] latch_buf;
    tpmc_coh_type coh_state;
    logic [2:0]  fix_sync;
    logic [2:0]  ext_sync;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        irq;
    // next values
    logic        next_overflow_flag;
    logic        next_overflow_irq_enable;
    logic        next_center_aligned_select;
    logic [1:0]  next_clock_select;
    logic [2:0]  next_prescale_field;
    logic        next_flag_armed;
    logic [15:0] next_modulo;
    logic [15:0] next_count;
    logic        next_count_down;
    logic [6:0]  next_prescale_cnt;
    logic [15:0] next_latch_buf;
    tpmc_coh_type next_coh_state;
    logic [2:0]  next_fix_sync;
    logic [2:0]  next_ext_sync;
    logic [31:0] next_prdata;
    logic        next_pready;
    logic        next_pslverr;
    logic        next_irq;
    // decode
    logic        access;
    logic        wr_status;
    logic        rd_status;
    logic        wr_count;
    logic        rd_high;
    logic        rd_low;
    logic        src_tick;
    logic        pre_tick;
    logic        overflow_evt;
    logic        free_run;
    logic [15:0] top;
    logic [7:0]  status_rd;

    // apb answers one cycle after the first access cycle: one wait state, pready pulses
    assign access    = psel_i && penable_i && !pready;
    assign wr_status = access && pwrite_i && paddr_i == TPMC_OFF_STATUS;
    assign rd_status = access && !pwrite_i && paddr_i == TPMC_OFF_STATUS;
    assign wr_count  = access && pwrite_i
                       && (paddr_i == TPMC_OFF_CNT_HIGH || paddr_i == TPMC_OFF_CNT_LOW);
    assign rd_high   = access && !pwrite_i && paddr_i == TPMC_OFF_CNT_HIGH;
    assign rd_low    = access && !pwrite_i && paddr_i == TPMC_OFF_CNT_LOW;
    assign status_rd = {overflow_flag, overflow_irq_enable, center_aligned_select,
                        clock_select, prescale_field};

    // clock source pick, edges from synchronised levels only
    always_comb begin
        next_fix_sync = {fix_sync[1:0], fixed_system_clock_i};  // [RULE_09]
        next_ext_sync = {ext_sync[1:0], external_pin_clock_i};  // [RULE_09]
        case (tpmc_clk_type'(clock_select))                     // [RULE_08]
            TPMC_CLK_NONE:  src_tick = 1'b0;
            TPMC_CLK_BUS:   src_tick = 1'b1;
            TPMC_CLK_FIXED: src_tick = fix_sync[1] && !fix_sync[2];
            TPMC_CLK_EXT:   src_tick = ext_sync[1] && !ext_sync[2];
            default:        src_tick = 1'b0;
        endcase
    end

    // prescaler after the selected source; tick when low bits roll over
    always_comb begin
        next_prescale_cnt = prescale_cnt;
        pre_tick          = 1'b0;
        if (src_tick && !debug_mode_i) begin                    // [RULE_12]
            next_prescale_cnt = prescale_cnt + 7'd1;
            pre_tick = (prescale_cnt & ((7'd1 << prescale_field) - 7'd1))
                       == ((7'd1 << prescale_field) - 7'd1);    // [RULE_11]
        end
        if (clock_select == TPMC_CLK_NONE) begin
            next_prescale_cnt = TPMC_PRE_RESET;
        end
    end

    // counter and direction
    always_comb begin
        free_run        = modulo == TPMC_MOD_RESET || modulo == TPMC_ALL_ONES;  // [RULE_19]
        top             = free_run ? TPMC_ALL_ONES : modulo;
        next_count      = count;
        next_count_down = count_down;
        overflow_evt    = 1'b0;
        if (pre_tick) begin                                     // [RULE_20]
            if (!center_aligned_select) begin                   // [RULE_07]
                next_count_down = 1'b0;
                if (count == top) begin
                    next_count   = TPMC_COUNT_RESET;            // [RULE_18]
                    overflow_evt = 1'b1;                        // [RULE_01]
                end else begin
                    next_count = count + 16'd1;
                end
            end else if (count_down) begin
                if (count == TPMC_COUNT_RESET) begin
                    next_count_down = 1'b0;
                    next_count      = count + 16'd1;
                end else begin
                    next_count = count - 16'd1;
                end
            end else if (count >= top) begin
                next_count_down = 1'b1;                         // [RULE_18]
                next_count      = count - 16'd1;
                overflow_evt    = 1'b1;                         // [RULE_02]
            end else begin
                next_count = count + 16'd1;
            end
        end
        if (wr_count) begin
            next_count      = TPMC_COUNT_RESET;                 // [RULE_17]
            next_count_down = 1'b0;
        end
    end

    // status/control and overflow flag clearing sequence
    always_comb begin
        next_overflow_flag         = overflow_flag;
        next_overflow_irq_enable   = overflow_irq_enable;
        next_center_aligned_select = center_aligned_select;
        next_clock_select          = clock_select;
        next_prescale_field        = prescale_field;
        next_flag_armed            = flag_armed;
        next_modulo                = modulo;
        if (rd_status && overflow_flag) begin
            next_flag_armed = 1'b1;                             // [RULE_03]
        end
        if (wr_status) begin
            next_overflow_irq_enable   = pwdata_i[TPMC_BIT_IRQEN];
            next_center_aligned_select = pwdata_i[TPMC_BIT_CENTER];
            next_clock_select          = pwdata_i[TPMC_BIT_CLKHI -: 2];
            next_prescale_field        = pwdata_i[TPMC_BIT_PSHI -: 3];
            // writing one to the flag does nothing
            if (!pwdata_i[TPMC_BIT_FLAG] && flag_armed) begin  // [RULE_05]
                next_overflow_flag = 1'b0;                      // [RULE_03]
            end
            next_flag_armed = 1'b0;
        end
        if (access && pwrite_i && paddr_i == TPMC_OFF_MODULO) begin
            next_modulo = pwdata_i[15:0];
        end
        // set beats clear and disarms any half-done sequence
        if (overflow_evt) begin
            next_overflow_flag = 1'b1;                          // [RULE_04]
            next_flag_armed    = 1'b0;                          // [RULE_04]
        end
        next_irq = next_overflow_flag && next_overflow_irq_enable;  // [RULE_06]
    end

    // read coherency buffer; debug freezes it in place
    always_comb begin
        next_coh_state = coh_state;
        next_latch_buf = latch_buf;
        if (!debug_mode_i) begin                                // [RULE_16]
            case (coh_state)
                TPMC_COH_IDLE: begin                            // [RULE_13]
                    if (rd_high) begin
                        next_coh_state = TPMC_COH_HIGH;
                        next_latch_buf = count;
                    end else if (rd_low) begin
                        next_coh_state = TPMC_COH_LOW;
                        next_latch_buf = count;
                    end
                end
                TPMC_COH_HIGH: if (rd_low) next_coh_state = TPMC_COH_IDLE;
                TPMC_COH_LOW:  if (rd_high) next_coh_state = TPMC_COH_IDLE;
                default:       next_coh_state = TPMC_COH_IDLE;
            endcase
        end
        if (wr_count || wr_status) begin
            next_coh_state = TPMC_COH_IDLE;                     // [RULE_14]
        end
    end

    // apb read mux; unmapped addresses answer with pslverr
    always_comb begin
        next_pready  = access;
        next_pslverr = 1'b0;
        next_prdata  = 32'h0000_0000;
        if (access) begin
            case (paddr_i)
                TPMC_OFF_STATUS:   next_prdata = {24'h00_0000, status_rd};
                TPMC_OFF_CNT_HIGH: next_prdata = {24'h00_0000,
                                   (coh_state == TPMC_COH_IDLE ? count[15:8]
                                                              : latch_buf[15:8])};
                TPMC_OFF_CNT_LOW:  next_prdata = {24'h00_0000,
                                   (coh_state == TPMC_COH_IDLE ? count[7:0]
                                                              : latch_buf[7:0])};
                TPMC_OFF_MODULO:   next_prdata = {16'h0000, modulo};
                default:           next_pslverr = 1'b1;
            endcase
        end
    end

    // registers
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            overflow_flag         <= TPMC_STATUS_RESET[TPMC_BIT_FLAG];    // [RULE_15]
            overflow_irq_enable   <= TPMC_STATUS_RESET[TPMC_BIT_IRQEN];   // [RULE_06]
            center_aligned_select <= TPMC_STATUS_RESET[TPMC_BIT_CENTER];
            clock_select          <= TPMC_STATUS_RESET[TPMC_BIT_CLKHI -: 2];
            prescale_field        <= TPMC_STATUS_RESET[TPMC_BIT_PSHI -: 3];
            flag_armed            <= 1'b0;
            modulo                <= TPMC_MOD_RESET;
            count                 <= TPMC_COUNT_RESET;                    // [RULE_15]
            count_down            <= 1'b0;
            prescale_cnt          <= TPMC_PRE_RESET;
            latch_buf             <= TPMC_COUNT_RESET;
            coh_state             <= TPMC_COH_IDLE;                       // [RULE_14]
            fix_sync              <= 3'b000;
            ext_sync              <= 3'b000;
            prdata                <= 32'h0000_0000;
            pready                <= 1'b0;
            pslverr               <= 1'b0;
            irq                   <= 1'b0;
        end else begin
            overflow_flag         <= next_overflow_flag;
            overflow_irq_enable   <= next_overflow_irq_enable;
            center_aligned_select <= next_center_aligned_select;
            clock_select          <= next_clock_select;
            prescale_field        <= next_prescale_field;
            flag_armed            <= next_flag_armed;
            modulo                <= next_modulo;
            count                 <= next_count;
            count_down            <= next_count_down;
            prescale_cnt          <= next_prescale_cnt;
            latch_buf             <= next_latch_buf;
            coh_state             <= next_coh_state;
            fix_sync              <= next_fix_sync;
            ext_sync              <= next_ext_sync;
            prdata                <= next_prdata;
            pready                <= next_pready;
            pslverr               <= next_pslverr;
            irq                   <= next_irq;
        end
    end

    // outputs straight from flops
    assign prdata_o         = prdata;
    assign pready_o         = pready;
    assign pslverr_o        = pslverr;
    assign overflow_irq_o   = irq;
    assign center_aligned_o = center_aligned_select;  // [RULE_07]
    assign count_o          = count;
endmodule

/* tb/tpmc_sva.sv */
// checker for tpmc_top: apb answers, counter steps, freeze, status side effects
// assumes it is bound to tpmc_top and sees its ports only
`timescale 1ns/100ps
module tpmc_sva
    import tpmc_pkg::*;
(
    input wire logic        sys_clk_i,
    input wire logic        sys_rst_i,
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic        pready_o,
    input wire logic        pslverr_o,
    input wire logic        debug_mode_i,
    input wire logic        overflow_irq_o,
    input wire logic        center_aligned_o,
    input wire logic [15:0] count_o
);
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (sys_rst_i);
    // request taken in its first access cycle; writes split by target
    logic take;
    logic st_wr;
    logic cnt_wr;
    assign take   = psel_i & penable_i & ~pready_o;
    assign st_wr  = take & pwrite_i & (paddr_i == TPMC_OFF_STATUS);
    assign cnt_wr = take & pwrite_i & (paddr_i inside {TPMC_OFF_CNT_HIGH, TPMC_OFF_CNT_LOW});
    property p_answer; take |=> pready_o; endproperty
    a_answer: assert property (p_answer) else $error("no answer after one wait state");
    property p_slverr; pready_o && paddr_i > TPMC_OFF_MODULO |-> pslverr_o; endproperty
    a_slverr: assert property (p_slverr) else $error("unmapped access not refused");
    property p_rst_cnt; $fell(sys_rst_i) |-> count_o == 16'h0000 && !overflow_irq_o; endproperty
    a_rst_cnt: assert property (p_rst_cnt) else $error("counter or request not clear");
    // a step is one count either way, or a wrap or clear to zero
    property p_step;
        count_o != $past(count_o) |-> count_o == $past(count_o) + 16'h0001
            || count_o == $past(count_o) - 16'h0001 || count_o == 16'h0000;
    endproperty
    a_step: assert property (p_step) else $error("counter jumped");
    property p_freeze; debug_mode_i [*2] |-> $stable(count_o); endproperty
    a_freeze: assert property (p_freeze) else $error("counter moved in debug");
    property p_cnt_wr; cnt_wr |=> count_o == 16'h0000; endproperty
    a_cnt_wr: assert property (p_cnt_wr) else $error("counter write did not clear");
    property p_center; st_wr |-> ##2 center_aligned_o == $past(pwdata_i[TPMC_BIT_CENTER], 2);
    endproperty
    a_center: assert property (p_center) else $error("center select not followed");
    property p_irq_off; st_wr && !pwdata_i[TPMC_BIT_IRQEN] |-> ##2 !overflow_irq_o; endproperty
    a_irq_off: assert property (p_irq_off) else $error("request with enable clear");
    // main scenarios seen
    c_irq: cover property ($rose(overflow_irq_o));
    c_center: cover property (center_aligned_o && count_o == 16'h0003);
    c_err: cover property (pslverr_o);
endmodule

bind tpmc_top tpmc_sva tpmc_sva_inst (.sys_clk_i, .sys_rst_i, .psel_i, .penable_i, .pwrite_i,
    .paddr_i, .pwdata_i, .pready_o, .pslverr_o, .debug_mode_i, .overflow_irq_o,
    .center_aligned_o, .count_o);

/* tb/tpmc_top_tb.sv */
// testbench for tpmc_top: status register, prescaler, sources, coherent reads
// assumes one apb wait state and a 100 MHz bus clock; no partner model
`timescale 1ns/100ps
module tpmc_top_tb
    import tpmc_pkg::*;
;
    localparam logic [11:0] ST = TPMC_OFF_STATUS;
    localparam logic [11:0] CH = TPMC_OFF_CNT_HIGH;
    localparam logic [11:0] CL = TPMC_OFF_CNT_LOW;
    localparam logic [31:0] Z  = 32'h0000_0000;
    // every design input has a value at time zero
    logic        sys_clk_i            = 1'b0;
    logic        sys_rst_i            = 1'b1;
    logic        psel_i               = 1'b0;
    logic        penable_i            = 1'b0;
    logic        pwrite_i             = 1'b0;
    logic [11:0] paddr_i              = 12'h000;
    logic [31:0] pwdata_i             = 32'h0000_0000;
    logic        fixed_system_clock_i = 1'b0;
    logic        external_pin_clock_i = 1'b0;
    logic        debug_mode_i         = 1'b0;
    logic [31:0] prdata_o;
    logic        pready_o;
    logic        pslverr_o;
    logic        overflow_irq_o;
    logic        center_aligned_o;
    logic [15:0] count_o;
    logic [31:0] rd;
    logic        er;
    logic [15:0] x;
    logic [15:0] v;
    logic [7:0]  lo;
    logic [7:0]  hi;
    int          err_total = 0;
    int          checks    = 0;
    // bus clock
    always #5 sys_clk_i = ~sys_clk_i;
    tpmc_top tpmc_top_inst (.sys_clk_i, .sys_rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
        .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .fixed_system_clock_i,
        .external_pin_clock_i, .debug_mode_i, .overflow_irq_o, .center_aligned_o, .count_o);
    // one transfer; request held until pready is seen high at an edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge sys_clk_i);
        psel_i   <= 1'b1;
        pwrite_i <= w;
        paddr_i  <= a;
        pwdata_i <= d;
        @(posedge sys_clk_i);
        penable_i <= 1'b1;
        do @(posedge sys_clk_i); while (pready_o !== 1'b1 && ++n < 20);
        rd = prdata_o;
        er = pslverr_o;
        psel_i    <= 1'b0;
        penable_i <= 1'b0;
        if (n >= 20) chk(1'b0, 1'b1);
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // bounded wait for a counter value, sampled away from the edge
    task automatic wait_cnt(input logic [15:0] w);
        int n;
        n = 0;
        while (count_o !== w && n < 3000) begin
            @(negedge sys_clk_i);
            n++;
        end
        chk(count_o, w);
    endtask
    task automatic do_reset();
        @(posedge sys_clk_i);
        sys_rst_i <= 1'b1;
        repeat (5) @(posedge sys_clk_i);
        sys_rst_i <= 1'b0;
    endtask
    // two byte reads 300 cycles apart must still form one 16-bit value
    task automatic read_pair(input bit low_first);
        x = count_o;
        apb(1'b0, low_first ? CL : CH, Z);
        lo = rd[7:0];
        hi = rd[7:0];
        repeat (300) @(negedge sys_clk_i);
        apb(1'b0, low_first ? CH : CL, Z);
        if (low_first) hi = rd[7:0];
        else lo = rd[7:0];
        v = x + {8'h00, 8'(lo - x[7:0])};
        chk(hi, v[15:8]);
        chk(8'(lo - x[7:0]) < 8'h08, 1'b1);
    endtask
    task automatic t_regs();
        apb(1'b0, ST, Z);
        chk(rd, Z);
        chk(er, 1'b0);
        chk(count_o, 16'h0000);
        apb(1'b0, 12'h010, Z);
        chk(er, 1'b1);
        chk(rd, Z);
        apb(1'b1, ST, 32'h0000_007F);
        apb(1'b0, ST, Z);
        chk(rd, 32'h0000_007F);
        $display("test regs done");
    endtask
    task automatic t_prescale();
        for (int ps = 0; ps < 8; ps++) begin
            apb(1'b1, ST, 32'h0000_0008 | 32'(ps));
            repeat (4) @(negedge sys_clk_i);
            x = count_o;
            repeat (8 << ps) @(negedge sys_clk_i);
            chk(16'(count_o - x), 16'h0008);
        end
        apb(1'b1, ST, Z);
        x = count_o;
        repeat (300) @(negedge sys_clk_i);
        chk(count_o, x);
        $display("test prescale done");
    endtask
    // slow pin edges only on the selected source
    task automatic t_sources();
        for (int s = 0; s < 2; s++) begin
            // no channel edge select exists here, so the pin clock has no rival driver
            apb(1'b1, ST, s ? 32'h0000_0018 : 32'h0000_0011);
            apb(1'b1, CL, 32'h0000_00A5);
            repeat (16) begin
                repeat (4) @(posedge sys_clk_i);
                if (s == 1) external_pin_clock_i <= ~external_pin_clock_i;
                else fixed_system_clock_i <= ~fixed_system_clock_i;
            end
            repeat (8) @(negedge sys_clk_i);
            chk(count_o, s ? 32'h0000_0008 : 32'h0000_0004);
        end
        $display("test sources done");
    endtask
    task automatic t_overflow();
        do_reset();
        apb(1'b1, TPMC_OFF_MODULO, 32'h0000_0005);
        apb(1'b0, TPMC_OFF_MODULO, Z);
        chk(rd, 32'h0000_0005);
        chk(er, 1'b0);
        apb(1'b1, ST, 32'h0000_0048);
        wait_cnt(16'h0005);
        @(negedge sys_clk_i);
        chk(count_o, 16'h0000);
        apb(1'b1, ST, 32'h0000_00C0);
        chk(overflow_irq_o, 1'b1);
        apb(1'b0, ST, Z);
        chk(rd, 32'h0000_00C0);
        apb(1'b1, ST, 32'h0000_0040);
        apb(1'b0, ST, Z);
        chk(rd, 32'h0000_0040);
        chk(overflow_irq_o, 1'b0);
        apb(1'b1, ST, 32'h0000_0008);
        repeat (8) @(negedge sys_clk_i);
        apb(1'b0, ST, Z);
        repeat (8) @(negedge sys_clk_i);
        apb(1'b1, ST, Z);
        apb(1'b0, ST, Z);
        chk(rd, 32'h0000_0080);
        chk(overflow_irq_o, 1'b0);
        $display("test overflow done");
    endtask
    task automatic t_center();
        do_reset();
        apb(1'b1, TPMC_OFF_MODULO, 32'h0000_0003);
        apb(1'b1, ST, 32'h0000_0028);
        wait_cnt(16'h0003);
        chk(center_aligned_o, 1'b1);
        for (int i = 1; i < 7; i++) begin
            @(negedge sys_clk_i);
            chk(count_o, i < 4 ? 3 - i : i - 3);
        end
        apb(1'b0, ST, Z);
        chk(rd, 32'h0000_00A8);
        $display("test center done");
    endtask
    task automatic t_coherent();
        do_reset();
        apb(1'b1, ST, 32'h0000_0008);
        repeat (600) @(negedge sys_clk_i);
        read_pair(1'b1);
        read_pair(1'b0);
        apb(1'b0, CL, Z);
        apb(1'b1, CH, 32'h0000_005A);
        apb(1'b1, ST, Z);
        apb(1'b0, CH, Z);
        chk(rd, Z);
        apb(1'b1, ST, 32'h0000_0008);
        debug_mode_i <= 1'b1;
        repeat (3) @(negedge sys_clk_i);
        x = count_o;
        apb(1'b0, CL, Z);
        repeat (20) @(negedge sys_clk_i);
        chk(count_o, x);
        @(posedge sys_clk_i);
        debug_mode_i <= 1'b0;
        repeat (300) @(negedge sys_clk_i);
        read_pair(1'b0);
        $display("test coherent done");
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // watchdog: the run needs under 10k cycles, so 40k means a hang
    initial begin
        #400_000;
        err_total++;
        $display("mismatch at %0t: watchdog expired", $time);
        report_and_stop();
    end
    // scenarios; resets before overflow, center and coherent keep the flag history clean
    initial begin
        do_reset();
        t_regs();
        t_prescale();
        t_sources();
        t_overflow();
        t_center();
        t_coherent();
        report_and_stop();
    end
endmodule
